// ### rtl/arrtb_map.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 counter array time base. Assumes inclusion by the package and the design.
*/
`ifndef ARRTB_MAP_SVH
`define ARRTB_MAP_SVH

// ==========================================================================
// Offsets
`define ARRTB_OFS_CTRL 8'hD8
`define ARRTB_OFS_MODE 8'hD9
`define ARRTB_OFS_CNT_LO 8'hDA
`define ARRTB_OFS_CNT_HI 8'hDB
`define ARRTB_OFS_IRQ_ST 8'hDC
`define ARRTB_OFS_IRQ_MASK 8'hDD

// ==========================================================================
// Mode register fields
`define ARRTB_MODE_IDLE_GATE 7
`define ARRTB_MODE_WDOG_EN 6
`define ARRTB_MODE_SRC_HI 2
`define ARRTB_MODE_SRC_LO 1
`define ARRTB_MODE_OVF_IE 0
`define ARRTB_MODE_WMASK 8'hC7

// ==========================================================================
// Control register fields
`define ARRTB_CTRL_OVF_FLAG 7
`define ARRTB_CTRL_RUN 6
`define ARRTB_CTRL_MOD_MSB 4

// ==========================================================================
// Reset values and timing
`define ARRTB_RST_MODE 8'h00
`define ARRTB_RST_CTRL 8'h00
`define ARRTB_DIV_SLOW 12
`define ARRTB_DIV_SLOW_X2 6
`define ARRTB_DIV_FAST 4
`define ARRTB_DIV_FAST_X2 2

`endif

// ### rtl/arrtb_pkg.sv
/*
 Types of the counter array time base. Assumes arrtb_map.svh beside it.
*/
`include "arrtb_map.svh"

package arrtb_pkg;
	typedef enum logic [1:0] {
		ARRTB_SRC_SLOW = 2'b00,
		ARRTB_SRC_FAST = 2'b01,
		ARRTB_SRC_T0OVF = 2'b10,
		ARRTB_SRC_EXT = 2'b11
	} arrtb_src_t;
endpackage

// ### rtl/arrtb_core.sv
/*
 Shared 16-bit time base of a five-module counter array: source select,
 run and idle gating, overflow and module flags, interrupt.
 Assumes one 10 MHz system clock; module events and timer 0 overflow are
 same-clock pulses; the external count pin is asynchronous.
*/
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "arrtb_map.svh"

// How it works
// - Idle gate set stops counter during idle
// - Watchdog enable bit drives module 4 watchdog
// - Two-bit field selects the count source
// - Overflow interrupt only when enable is set
// - Counter runs only while run bit set
// - Hardware sets overflow flag on rollover
// - Only software write of zero clears overflow
// - Bits 0..4 flag per-module match or capture
// - Only software clears the module flags
// - One counter is shared by five modules
module arrtb_core import arrtb_pkg::*; #(
	parameter int CNT_W = 16,
	parameter int N_MOD = 5
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic idle_mode_in,
	input wire logic double_speed_mode_in,
	input wire logic timer0_ovf_in,
	input wire logic external_count_input_in,
	input wire logic [N_MOD-1:0] module_event_in,
	output logic [CNT_W-1:0] count_out,
	output logic count_tick_out,
	output logic module4_watchdog_enable_out,
	output logic irq_out
);

	// ======================================================================
	// Register decode
	logic [7:0] mode_r;
	logic ovf_flag_r;
	logic run_r;
	logic [N_MOD-1:0] mod_flag_r;
	logic [CNT_W-1:0] cnt_r;
	logic [7:0] irq_st_r;
	logic [7:0] irq_mask_r;
	logic [7:0] rdata_r;

	wire wr_ctrl = wr_in && (addr_in == `ARRTB_OFS_CTRL);
	wire wr_mode = wr_in && (addr_in == `ARRTB_OFS_MODE);
	wire wr_lo = wr_in && (addr_in == `ARRTB_OFS_CNT_LO);
	wire wr_hi = wr_in && (addr_in == `ARRTB_OFS_CNT_HI);
	wire wr_ist = wr_in && (addr_in == `ARRTB_OFS_IRQ_ST);
	wire wr_imask = wr_in && (addr_in == `ARRTB_OFS_IRQ_MASK);

	wire [7:0] ctrl_view = {ovf_flag_r, run_r, 1'b0, 5'(mod_flag_r)};
	wire idle_gate = mode_r[`ARRTB_MODE_IDLE_GATE];
	wire ovf_ie = mode_r[`ARRTB_MODE_OVF_IE];
	wire [1:0] src_sel = {mode_r[`ARRTB_MODE_SRC_HI], mode_r[`ARRTB_MODE_SRC_LO]};

	// ======================================================================
	// Count sources
	logic [3:0] div_r;
	logic ext_s1_r;
	logic ext_s2_r;
	logic ext_s3_r;

	wire [3:0] div_top = double_speed_mode_in
		? ((src_sel == 2'b00) ? 4'(`ARRTB_DIV_SLOW_X2 - 1) : 4'(`ARRTB_DIV_FAST_X2 - 1))
		: ((src_sel == 2'b00) ? 4'(`ARRTB_DIV_SLOW - 1) : 4'(`ARRTB_DIV_FAST - 1));
	wire div_tick = (div_r >= div_top);
	// Only the second and third stages feed the edge detector
	wire ext_rise = ext_s2_r && !ext_s3_r;

	logic src_pulse;
	always_comb begin
		unique case (arrtb_src_t'(src_sel))
			ARRTB_SRC_SLOW: src_pulse = div_tick;
			ARRTB_SRC_FAST: src_pulse = div_tick;
			ARRTB_SRC_T0OVF: src_pulse = timer0_ovf_in;
			ARRTB_SRC_EXT: src_pulse = ext_rise;
		endcase
	end

	// Pin sampled at 10 MHz, so rises faster than osc/2 may be missed
	wire cnt_en = run_r && !(idle_gate && idle_mode_in);
	wire tick = cnt_en && src_pulse;
	wire wrap = tick && (cnt_r == {CNT_W{1'b1}});

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_r <= 4'h0;
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end else begin
			// Prescaler only advances while counting so a stop freezes phase
			if (cnt_en) begin
				div_r <= div_tick ? 4'h0 : div_r + 4'h1;
			end
			ext_s1_r <= external_count_input_in;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end

	// ======================================================================
	// Time base counter, shared by all modules
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= '0;
		end else if (wr_lo) begin
			cnt_r[7:0] <= wdata_in;
		end else if (wr_hi) begin
			cnt_r[CNT_W-1:8] <= wdata_in[CNT_W-9:0];
		end else if (tick) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// ======================================================================
	// Mode and control registers
	// Hardware set wins over a software clear in the same cycle
	wire [N_MOD-1:0] mod_flag_nxt = (wr_ctrl ? (mod_flag_r & wdata_in[N_MOD-1:0]) : mod_flag_r)
		| module_event_in;
	wire ovf_flag_nxt = wrap ? 1'b1
		: (wr_ctrl ? wdata_in[`ARRTB_CTRL_OVF_FLAG] : ovf_flag_r);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_r <= `ARRTB_RST_MODE;
			run_r <= 1'b0;
			ovf_flag_r <= 1'b0;
			mod_flag_r <= '0;
		end else begin
			if (wr_mode) begin
				mode_r <= wdata_in & `ARRTB_MODE_WMASK;
			end
			if (wr_ctrl) begin
				run_r <= wdata_in[`ARRTB_CTRL_RUN];
			end
			ovf_flag_r <= ovf_flag_nxt;
			mod_flag_r <= mod_flag_nxt;
		end
	end

	// ======================================================================
	// Interrupt status: bit 7 overflow, bits 0..4 module events
	wire [7:0] ev_vec = {wrap, 2'b00, 5'(module_event_in)};
	wire [7:0] irq_st_nxt = (wr_ist ? (irq_st_r & ~wdata_in) : irq_st_r) | ev_vec;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_st_r <= 8'h00;
			irq_mask_r <= 8'h00;
		end else begin
			irq_st_r <= irq_st_nxt;
			if (wr_imask) begin
				irq_mask_r <= wdata_in;
			end
		end
	end

	// Overflow path also obeys the mode register enable
	wire irq_ovf = ovf_ie && ovf_flag_r && irq_mask_r[7] && irq_st_r[7];
	wire irq_mod = |(irq_st_r[6:0] & irq_mask_r[6:0]);
	assign irq_out = irq_ovf || irq_mod;

	// ======================================================================
	// Read path
	logic [7:0] rsel;
	always_comb begin
		unique case (addr_in)
			`ARRTB_OFS_CTRL: rsel = ctrl_view;
			`ARRTB_OFS_MODE: rsel = mode_r;
			`ARRTB_OFS_CNT_LO: rsel = cnt_r[7:0];
			`ARRTB_OFS_CNT_HI: rsel = cnt_r[CNT_W-1:8];
			`ARRTB_OFS_IRQ_ST: rsel = irq_st_r;
			`ARRTB_OFS_IRQ_MASK: rsel = irq_mask_r;
			default: rsel = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_r <= 8'h00;
		end else if (rd_in) begin
			rdata_r <= rsel;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign rdata_out = rdata_r;
	assign count_out = cnt_r;
	assign count_tick_out = tick;
	assign module4_watchdog_enable_out = mode_r[`ARRTB_MODE_WDOG_EN];

	// ======================================================================
	// Checks
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_ovf_sets_flag: assert property (wrap |=> ovf_flag_r) else $error("overflow flag not set");
	a_ovf_no_hw_clr: assert property (ovf_flag_r && !wr_ctrl |=> ovf_flag_r)
		else $error("overflow flag cleared by hardware");
	a_mod_flag_set: assert property (module_event_in[0] |=> mod_flag_r[0])
		else $error("module flag not set");
	a_mod_no_hw_clr: assert property (mod_flag_r[4] && !wr_ctrl |=> mod_flag_r[4])
		else $error("module flag cleared by hardware");
	a_run_stops: assert property (!run_r |=> $stable(cnt_r) || $past(wr_lo) || $past(wr_hi))
		else $error("counter moved while stopped");
	a_idle_stops: assert property (idle_gate && idle_mode_in |-> !tick)
		else $error("counter ticked in gated idle");
	a_irq_gate: assert property (!ovf_ie && irq_st_r[6:0] == 7'h00 |-> !irq_out)
		else $error("overflow interrupt without enable");
	a_wrap_zero: assert property (wrap && !wr_lo && !wr_hi |=> cnt_r == '0)
		else $error("counter did not wrap to zero");
	a_ext_count: assert property (src_sel == 2'b11 && cnt_en && ext_rise |-> tick)
		else $error("external rise not counted");
	a_wdog_out: assert property (wr_mode
		|=> module4_watchdog_enable_out == $past(wdata_in[6]))
		else $error("watchdog enable not applied");
	a_slow_div: assert property (src_sel == 2'b00 && !double_speed_mode_in && cnt_en && tick
		&& !wr_mode ##1 (cnt_en && !wr_mode && !wr_in)[*8] |-> !tick)
		else $error("slow source ticked early");
	a_slow_x2_div: assert property (src_sel == 2'b00 && double_speed_mode_in && tick
		&& !wr_in ##1 (cnt_en && double_speed_mode_in && !wr_in)[*5] |-> !tick)
		else $error("slow double speed source ticked early");
	a_fast_div: assert property (src_sel == 2'b01 && !double_speed_mode_in && tick
		&& !wr_in ##1 (cnt_en && !double_speed_mode_in && !wr_in)[*3] |-> !tick)
		else $error("fast source ticked early");
	a_fast_x2_div: assert property (src_sel == 2'b01 && double_speed_mode_in && tick
		&& !wr_in ##1 (cnt_en && double_speed_mode_in && !wr_in)[*1] |-> !tick)
		else $error("fast double speed source ticked early");

	// ======================================================================
	// Flag checks, one set per compare module
	for (genvar m = 0; m < N_MOD; m++) begin : g_flag_chk
		a_flag_set_each: assert property (module_event_in[m] |=> mod_flag_r[m])
			else $error("module flag not set by its event");
		a_flag_hold_each: assert property (mod_flag_r[m] && !wr_ctrl |=> mod_flag_r[m])
			else $error("module flag lost without a write");
		a_flag_sw_clr: assert property (wr_ctrl && !wdata_in[m] && !module_event_in[m]
			|=> !mod_flag_r[m])
			else $error("module flag not cleared by software");
	end

	a_ovf_sw_clr: assert property (wr_ctrl && !wdata_in[7] && !wrap
		|=> !ovf_flag_r)
		else $error("overflow flag not cleared by software");
	a_ovf_sw_set: assert property (wr_ctrl && wdata_in[7]
		|=> ovf_flag_r)
		else $error("overflow flag not set by software");
	a_irq_ovf_on: assert property (ovf_ie && ovf_flag_r && irq_mask_r[7] && irq_st_r[7]
		|-> irq_out)
		else $error("overflow interrupt missing");
	a_mode_reserved: assert property (mode_r[5:3] == 3'h0)
		else $error("reserved mode bits not zero");

	// ======================================================================
	// Counting checks
	// Cycles the counter has sat stopped with no software write to it;
	// a counter of cycles keeps the check cheap however long the stop lasts
	logic [7:0] stop_len_r;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			stop_len_r <= 8'h00;
		end else if (cnt_en || wr_lo || wr_hi) begin
			stop_len_r <= 8'h00;
		end else if (stop_len_r != 8'hFF) begin
			stop_len_r <= stop_len_r + 8'h01;
		end
	end

	a_stop_hold: assert property (stop_len_r != 8'h00
		|-> $stable(cnt_r))
		else $error("stopped counter moved");
	a_run_bit: assert property (wr_ctrl
		|=> run_r == $past(wdata_in[`ARRTB_CTRL_RUN]))
		else $error("run bit not written");
	a_tick_needs_run: assert property (tick
		|-> run_r)
		else $error("counter ticked while stopped");
	a_div_freeze: assert property (!cnt_en
		|=> $stable(div_r))
		else $error("prescaler moved while stopped");
	a_t0_count: assert property (src_sel == 2'b10
		|-> tick == (cnt_en && timer0_ovf_in))
		else $error("timer 0 overflow not counted");
	a_idle_free: assert property (!idle_gate && run_r && src_sel == 2'b10 && timer0_ovf_in
		|-> tick)
		else $error("counter held in ungated idle");
	a_ext_single: assert property (ext_rise
		|=> !ext_rise)
		else $error("one pin rise counted twice");
	a_tick_step: assert property (tick && !wr_lo && !wr_hi
		|=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("counter did not step by one");
	a_lo_write: assert property (wr_lo
		|=> cnt_r[7:0] == $past(wdata_in))
		else $error("counter low byte not written");
	a_hi_write: assert property (wr_hi
		|=> cnt_r[CNT_W-1:8] == $past(wdata_in[CNT_W-9:0]))
		else $error("counter high byte not written");

	// ======================================================================
	// Interrupt status and bus checks
	a_ovf_status: assert property (wrap
		|=> irq_st_r[7])
		else $error("overflow status not set");
	a_ist_w1c: assert property (wr_ist && wdata_in[0] && !module_event_in[0]
		|=> !irq_st_r[0])
		else $error("status bit not cleared by a one");
	a_mask_write: assert property (wr_imask
		|=> irq_mask_r == $past(wdata_in))
		else $error("interrupt mask not written");
	a_mod_irq: assert property (|(irq_st_r[4:0] & irq_mask_r[4:0])
		|-> irq_out)
		else $error("module interrupt missing");
	a_rdata_idle: assert property (!rd_in
		|=> rdata_out == 8'h00)
		else $error("read data stood past its cycle");

	c_wrap: cover property (wrap);
	c_ext_tick: cover property (src_sel == 2'b11 && tick);
	c_irq: cover property (irq_out);
	c_set_clear: cover property (wr_ctrl && module_event_in[0]);
	c_idle_gated: cover property (idle_gate && idle_mode_in && run_r);

endmodule

// ### test/tb_array_timebase_control.sv
/*
 Self-checking bench of the counter array time base: registers, count sources, gating, flags.
 Assumes the package and the register map header are compiled before it.
*/
`timescale 1ns/1ps
`include "arrtb_map.svh"
module tb_array_timebase_control import arrtb_pkg::*;;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic idle_mode_in = 1'b0;
	logic double_speed_mode_in = 1'b0;
	logic timer0_ovf_in = 1'b0;
	logic external_count_input_in = 1'b0;
	logic [4:0] module_event_in = 5'h00;
	logic [7:0] rdata_out;
	logic [15:0] count_out;
	logic count_tick_out;
	logic module4_watchdog_enable_out;
	logic irq_out;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	int k;
	logic [31:0] seed = 32'h4B76;
	logic [7:0] d;
	logic [7:0] v;
	logic [15:0] c0;
	logic [15:0] dl;
	logic [4:0] acc;
	arrtb_core dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .idle_mode_in(idle_mode_in),
		.double_speed_mode_in(double_speed_mode_in), .timer0_ovf_in(timer0_ovf_in),
		.external_count_input_in(external_count_input_in), .module_event_in(module_event_in),
		.count_out(count_out), .count_tick_out(count_tick_out),
		.module4_watchdog_enable_out(module4_watchdog_enable_out), .irq_out(irq_out));
	// ==========================================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int exp_ticks(input logic [1:0] src, input logic x2, input int n);
		if (src == 2'b00)
			return n / (x2 ? `ARRTB_DIV_SLOW_X2 : `ARRTB_DIV_SLOW);
		return n / (x2 ? `ARRTB_DIV_FAST_X2 : `ARRTB_DIV_FAST);
	endfunction
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	// Each bus task ends 1 ns past the edge so callers sample settled values
	task automatic wr(input logic [7:0] a, input logic [7:0] val);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= val;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask
	task automatic span(input int n);
		@(posedge clk_in);
		#1 c0 = count_out;
		repeat (n) @(posedge clk_in);
		#1 dl = count_out - c0;
	endtask
	task automatic pulse_t0(input int n);
		repeat (n) begin
			@(posedge clk_in);
			timer0_ovf_in <= 1'b1;
			@(posedge clk_in);
			timer0_ovf_in <= 1'b0;
		end
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================================
	// Clock and hang guard
	initial begin
		forever #50 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	// ==========================================================================
	// Scenarios
	initial begin
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(`ARRTB_OFS_CTRL);
		chk("control reset", d, `ARRTB_RST_CTRL);
		@(posedge clk_in);
		#1 chk("read data drops", rdata_out, 8'h00);
		rd(8'hE0);
		chk("unmapped read", d, 8'h00);
		seed = lfsr(seed);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0] ^ 8'(i);
			wr(`ARRTB_OFS_MODE, v);
			rd(`ARRTB_OFS_MODE);
			chk("mode readback", d, v & `ARRTB_MODE_WMASK);
			chk("watchdog enable", module4_watchdog_enable_out, v[6]);
		end
		$display("test mode register done");
		for (int x2 = 0; x2 < 2; x2++) begin
			double_speed_mode_in <= x2[0];
			for (int s = 0; s < 2; s++) begin
				wr(`ARRTB_OFS_MODE, {5'h00, s[1:0], 1'b0});
				wr(`ARRTB_OFS_CTRL, 8'h40);
				repeat (12) @(posedge clk_in);
				span(120);
				chk("prescaled ticks", dl, exp_ticks(s[1:0], x2[0], 120));
				wr(`ARRTB_OFS_CTRL, 8'h00);
				span(24);
				chk("stopped count", dl, 16'h0000);
			end
		end
		double_speed_mode_in <= 1'b0;
		wr(`ARRTB_OFS_MODE, 8'h82);
		wr(`ARRTB_OFS_CTRL, 8'h40);
		idle_mode_in <= 1'b1;
		span(40);
		chk("idle gated", dl, 16'h0000);
		wr(`ARRTB_OFS_MODE, {5'h00, ARRTB_SRC_FAST, 1'b0});
		repeat (8) @(posedge clk_in);
		span(40);
		chk("idle running", dl, 16'd10);
		idle_mode_in <= 1'b0;
		wr(`ARRTB_OFS_MODE, {5'h00, ARRTB_SRC_T0OVF, 1'b0});
		seed = lfsr(seed);
		k = seed[2:0] + 1;
		c0 = count_out;
		pulse_t0(k);
		chk("timer0 ticks", count_out - c0, 16'(k));
		@(posedge clk_in);
		timer0_ovf_in <= 1'b1;
		#1 chk("tick output", count_tick_out, 1'b1);
		@(posedge clk_in);
		timer0_ovf_in <= 1'b0;
		#1 chk("tick output low", count_tick_out, 1'b0);
		wr(`ARRTB_OFS_MODE, {5'h00, ARRTB_SRC_EXT, 1'b0});
		c0 = count_out;
		// Pin toggles every 4 cycles: a quarter of the fastest rate the pin may run
		repeat (k + 2) begin
			external_count_input_in <= 1'b1;
			repeat (4) @(posedge clk_in);
			external_count_input_in <= 1'b0;
			repeat (4) @(posedge clk_in);
		end
		#1 chk("external rises", count_out - c0, 16'(k + 2));
		$display("test count sources done");
		wr(`ARRTB_OFS_CTRL, 8'h00);
		wr(`ARRTB_OFS_MODE, {5'h00, ARRTB_SRC_T0OVF, 1'b1});
		wr(`ARRTB_OFS_CNT_LO, 8'hFF);
		wr(`ARRTB_OFS_CNT_HI, 8'hFF);
		wr(`ARRTB_OFS_IRQ_MASK, 8'h80);
		wr(`ARRTB_OFS_CTRL, 8'h40);
		pulse_t0(1);
		chk("wrapped count", count_out, 16'h0000);
		rd(`ARRTB_OFS_CTRL);
		chk("overflow flag", d, 8'hC0);
		chk("overflow irq", irq_out, 1'b1);
		wr(`ARRTB_OFS_MODE, {5'h00, ARRTB_SRC_T0OVF, 1'b0});
		chk("overflow irq off", irq_out, 1'b0);
		repeat (20) @(posedge clk_in);
		rd(`ARRTB_OFS_CTRL);
		chk("overflow held", d, 8'hC0);
		wr(`ARRTB_OFS_CTRL, 8'h40);
		rd(`ARRTB_OFS_CTRL);
		chk("overflow cleared", d, 8'h40);
		$display("test overflow done");
		wr(`ARRTB_OFS_CTRL, 8'h00);
		wr(`ARRTB_OFS_IRQ_ST, 8'hFF);
		wr(`ARRTB_OFS_IRQ_MASK, 8'h1F);
		acc = 5'h00;
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			@(posedge clk_in);
			module_event_in <= seed[4:0] | (5'h01 << i);
			@(posedge clk_in);
			module_event_in <= 5'h00;
			acc |= seed[4:0] | (5'h01 << i);
			repeat (8) @(posedge clk_in);
			rd(`ARRTB_OFS_CTRL);
			chk("module flags", d, {3'b000, acc});
		end
		chk("module irq", irq_out, 1'b1);
		wr(`ARRTB_OFS_CTRL, 8'h1F);
		rd(`ARRTB_OFS_CTRL);
		chk("flags kept", d, {3'b000, acc});
		wr(`ARRTB_OFS_CTRL, 8'h00);
		rd(`ARRTB_OFS_CTRL);
		chk("flags cleared", d, 8'h00);
		wr(`ARRTB_OFS_IRQ_ST, 8'hFF);
		chk("irq cleared", irq_out, 1'b0);
		$display("test module flags done");
		report_and_stop();
	end
endmodule
